//--- core/rtcw_pkg.sv
// Shared constants for the clock supervisor: register map, fields, timing
package rtcw_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h08;
  localparam logic [7:0] ADDR_WDOG     = 8'h09;
  localparam logic [7:0] ADDR_AL_MONTH = 8'h0A;
  localparam logic [7:0] ADDR_AL_DATE  = 8'h0B;
  localparam logic [7:0] ADDR_AL_HOUR  = 8'h0C;
  localparam logic [7:0] ADDR_AL_MIN   = 8'h0D;
  localparam logic [7:0] ADDR_AL_SEC   = 8'h0E;
  localparam logic [7:0] ADDR_FLAGS    = 8'h0F;
  localparam logic [7:0] ADDR_SQW      = 8'h13;

  // Reset value of every register
  localparam logic [7:0] REG_RESET = 8'h00;

  // Bit positions
  localparam int CTRL_OUT_BIT = 7;
  localparam int CTRL_FT_BIT  = 6;
  localparam int WD_STEER_BIT = 7;
  localparam int AM_AFE_BIT   = 7;
  localparam int AM_SQUARE_WAVE_GATE_BIT  = 6;
  localparam int AM_ABE_BIT   = 5;
  localparam int RPT_HI_BIT   = 7;
  localparam int RPT5_BIT     = 6;
  localparam int FLG_WDF_BIT  = 7;
  localparam int FLG_AF_BIT   = 6;
  localparam int SQW_RS_LSB   = 4;

  // BCD field masks of the alarm registers
  localparam logic [7:0] MASK_MONTH = 8'h1F;
  localparam logic [7:0] MASK_DATE  = 8'h3F;
  localparam logic [7:0] MASK_HOUR  = 8'h3F;
  localparam logic [7:0] MASK_MIN   = 8'h7F;
  localparam logic [7:0] MASK_SEC   = 8'h7F;

  // Repeat codes, order {rpt5,rpt4,rpt3,rpt2,rpt1}
  localparam logic [4:0] RPT_SECOND = 5'h1F;
  localparam logic [4:0] RPT_MINUTE = 5'h1E;
  localparam logic [4:0] RPT_HOUR   = 5'h1C;
  localparam logic [4:0] RPT_DAY    = 5'h18;
  localparam logic [4:0] RPT_MONTH  = 5'h10;
  localparam logic [4:0] RPT_YEAR   = 5'h00;

  // Watchdog resolutions in 1/16 s ticks
  localparam logic [6:0] RES_SIXTEENTH = 7'h01;
  localparam logic [6:0] RES_QUARTER   = 7'h04;
  localparam logic [6:0] RES_ONE       = 7'h10;
  localparam logic [6:0] RES_FOUR      = 7'h40;

  // Oscillator divider (link clock runs at twice the crystal rate)
  localparam int OSC_HZ      = 65536;
  localparam int DIV_W       = 16;
  localparam int TICK16_BIT  = 11;
  localparam int FT_BIT      = 6;

  // Timing
  localparam int SYS_HZ        = 100_000_000;
  localparam int RESET_HOLD_MS = 40;

endpackage

//--- core/rtcw_sqw_gen.sv
// Oscillator-domain divider chain and square-wave output
module rtcw_sqw_gen #(
  parameter int DIV_W = rtcw_pkg::DIV_W
) (
  input  wire logic       osc_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] rate_sel,
  input  wire logic       gate,
  output logic            sqw_out,
  output logic            tick_level,
  output logic            ft_level
);

  typedef struct packed {
    logic [1:0]       rst_sync;
    logic [3:0]       rate_s1;
    logic [3:0]       rate_s2;
    logic             gate_s1;
    logic             gate_s2;
    logic [DIV_W-1:0] div;
    logic             wave;
  } rtcw_osc_t;

  rtcw_osc_t r;
  rtcw_osc_t next_r;

  // Control bits are quasi-static; per-bit sync may glitch one osc cycle on change
  always_comb begin
    next_r          = r;
    next_r.rst_sync = {r.rst_sync[0], rstn};
    next_r.rate_s1  = rate_sel;
    next_r.rate_s2  = r.rate_s1;
    next_r.gate_s1  = gate;
    next_r.gate_s2  = r.gate_s1;
    next_r.div      = r.div + 1'b1;
    // Code 1 taps bit 0, code n above 1 taps bit n
    if (!r.gate_s2 || r.rate_s2 == 4'h0) begin
      next_r.wave = 1'b0;
    end else if (r.rate_s2 == 4'h1) begin
      next_r.wave = r.div[0];
    end else begin
      next_r.wave = r.div[r.rate_s2];
    end
    if (!r.rst_sync[1]) begin
      next_r.div  = '0;
      next_r.wave = 1'b0;
    end
  end

  // Single register stage for the whole domain
  always_ff @(posedge osc_clk) begin
    r <= next_r;
  end

  assign sqw_out    = r.wave;
  assign tick_level = r.div[rtcw_pkg::TICK16_BIT];
  assign ft_level   = r.div[rtcw_pkg::FT_BIT];

endmodule

//--- core/rtcw_supervisor.sv
// Alarm, watchdog, interrupt pin, reset pin and square-wave supervisor
//
// Contract
// - Alarm flag set on selected-field time match
// - Enabled alarm match drives the interrupt pin
// - Repeat bits pick second through year period
// - Undefined repeat codes behave as per-second
// - Pointer on flags register defers alarm event
// - Pointer auto-increments, alarm seconds to flags
// - Flags read releases pin, clears alarm flag
// - Battery mode needs both alarm enables
// - Power-up clears both alarm enables
// - Low watchdog bits select the resolution
// - Timeout equals multiplier times resolution
// - Expired watchdog sets flag, interrupt or reset
// - Flags read clears watchdog flag
// - Steering bit picks pin or reset pulse
// - Reset-steered timeout clears enables and watchdog
// - Kick edge or register write restarts
// - Writing zero releases pin, keeps watchdog off
// - Power-up clears the watchdog register
// - Interrupt-steered watchdog overrides frequency test
// - Rate code selects square-wave frequency
// - Square wave only while its gate set
// - Power fail holds reset low for hold time
// - Alarm fields held and compared in BCD
module rtcw_supervisor #(
  parameter int unsigned RESET_HOLD_CYC = (rtcw_pkg::SYS_HZ / 1000) * rtcw_pkg::RESET_HOLD_MS,
  parameter int          DIV_W          = rtcw_pkg::DIV_W
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       osc_clk,
  input  wire logic       ptr_load,
  input  wire logic [7:0] ptr_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       time_tick,
  input  wire logic [7:0] cur_month,
  input  wire logic [7:0] cur_date,
  input  wire logic [7:0] cur_hour,
  input  wire logic [7:0] cur_min,
  input  wire logic [7:0] cur_sec,
  input  wire logic       on_battery,
  input  wire logic       power_fail,
  input  wire logic       watchdog_kick_input,
  output logic            interrupt_test_output_pin_o,
  output logic            interrupt_test_output_pin_oe_n,
  output logic            reset_o,
  output logic            reset_oe_n,
  output logic            square_wave_output
);

  // Whole sys_clk-domain state, registered in one stage
  typedef struct packed {
    // Host-visible registers and pointer
    logic [7:0]  ptr;
    logic [7:0]  rdata;
    logic [1:0]  ctrl;
    logic [7:0]  wdog;
    logic [7:0]  al_month;
    logic [7:0]  al_date;
    logic [7:0]  al_hour;
    logic [7:0]  al_min;
    logic [7:0]  al_sec;
    logic [3:0]  rate;
    // Flags and pin requests
    logic        alarm_flag;
    logic        watchdog_flag;
    logic        alarm_irq;
    logic        alarm_pend;
    logic        wd_irq;
    logic        wd_hold;
    // Timers
    logic [11:0] wd_cnt;
    logic [31:0] rst_cnt;
    // Synchroniser stages
    logic [2:0]  tick_s;
    logic [1:0]  ft_s;
    logic [2:0]  kick_s;
    logic [1:0]  batt_s;
    logic [1:0]  pf_s;
    // Registered pin drives
    logic        pin_lvl;
    logic        pin_oe_n;
    logic        rst_lvl;
    logic        rst_oe_n;
  } rtcw_state_t;

  rtcw_state_t r;
  rtcw_state_t next_r;

  // Levels from the oscillator domain, synchronised below
  logic tick_level;
  logic ft_level;

  // Hold count cut to the counter width on purpose
  localparam logic [31:0] HOLD_CYC = RESET_HOLD_CYC[31:0];
  // All-zero register byte, also the power-up value
  localparam logic [7:0]  REG_ZERO = rtcw_pkg::REG_RESET;

  // Compare enables {month,date,hour,min,sec} for a repeat code
  // Unlisted codes fall back to per-second so a bad setting shows at once
  function automatic logic [4:0] rtcw_rpt_mask(input logic [4:0] rpt);
    logic [4:0] m;
    m = 5'h00;
    case (rpt)
      rtcw_pkg::RPT_SECOND: m = 5'h00;
      rtcw_pkg::RPT_MINUTE: m = 5'h01;
      rtcw_pkg::RPT_HOUR:   m = 5'h03;
      rtcw_pkg::RPT_DAY:    m = 5'h07;
      rtcw_pkg::RPT_MONTH:  m = 5'h0F;
      rtcw_pkg::RPT_YEAR:   m = 5'h1F;
      default:              m = 5'h00;
    endcase
    return m;
  endfunction

  // Masked BCD field equality
  // Masks drop the repeat and enable bits that share the bytes
  function automatic logic rtcw_field_eq(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [7:0] mask);
    return (a & mask) == (b & mask);
  endfunction

  // Timeout length in 1/16 s ticks
  function automatic logic [11:0] rtcw_wd_limit(input logic [7:0] wd);
    logic [6:0] res;
    res = rtcw_pkg::RES_SIXTEENTH;
    case (wd[1:0])
      2'h0:    res = rtcw_pkg::RES_SIXTEENTH;
      2'h1:    res = rtcw_pkg::RES_QUARTER;
      2'h2:    res = rtcw_pkg::RES_ONE;
      default: res = rtcw_pkg::RES_FOUR;
    endcase
    // Widen before the product; 31 times 64 needs 11 bits
    return 12'(wd[6:2]) * 12'(res);
  endfunction

  // Divider chain and square wave live on the oscillator clock
  rtcw_sqw_gen #(
    .DIV_W (DIV_W)
  ) u_sqw (
    .osc_clk    (osc_clk),
    .rstn       (rstn),
    .rate_sel   (r.rate),
    .gate       (r.al_month[rtcw_pkg::AM_SQUARE_WAVE_GATE_BIT]),
    .sqw_out    (square_wave_output),
    .tick_level (tick_level),
    .ft_level   (ft_level)
  );

  // Combinational decode results
  logic [4:0] rpt;
  logic [4:0] cmp_en;
  logic       match;
  logic       hit;
  logic       at_flags;
  logic       wr_wdog;
  logic       rd_flags;
  logic       tick16;
  logic       kick;
  logic       wd_en;
  logic       wd_to_irq;
  logic       expire;
  logic       alarm_event;

  // Decode of the current alarm setting and access strobes
  always_comb begin
    rpt    = {r.al_date[rtcw_pkg::RPT5_BIT], r.al_date[rtcw_pkg::RPT_HI_BIT],
              r.al_hour[rtcw_pkg::RPT_HI_BIT], r.al_min[rtcw_pkg::RPT_HI_BIT],
              r.al_sec[rtcw_pkg::RPT_HI_BIT]};
    cmp_en = rtcw_rpt_mask(rpt);
    // A disabled field always counts as matching
    match  = (!cmp_en[4] || rtcw_field_eq(cur_month, r.al_month, rtcw_pkg::MASK_MONTH)) &&
             (!cmp_en[3] || rtcw_field_eq(cur_date, r.al_date, rtcw_pkg::MASK_DATE)) &&
             (!cmp_en[2] || rtcw_field_eq(cur_hour, r.al_hour, rtcw_pkg::MASK_HOUR)) &&
             (!cmp_en[1] || rtcw_field_eq(cur_min, r.al_min, rtcw_pkg::MASK_MIN)) &&
             (!cmp_en[0] || rtcw_field_eq(cur_sec, r.al_sec, rtcw_pkg::MASK_SEC));
    hit       = time_tick && match;
    at_flags  = r.ptr == rtcw_pkg::ADDR_FLAGS;
    wr_wdog   = reg_wr && r.ptr == rtcw_pkg::ADDR_WDOG;
    rd_flags  = reg_rd && at_flags;
    tick16    = r.tick_s[1] && !r.tick_s[2];
    kick      = r.kick_s[1] ^ r.kick_s[2];
    wd_en     = r.wdog[6:2] != 5'h00;
    wd_to_irq = wd_en && !r.wdog[rtcw_pkg::WD_STEER_BIT];
    // A restart in the same cycle wins over the timeout
    expire    = tick16 && wd_en && !r.wd_hold &&
                !wr_wdog && !kick &&
                (r.wd_cnt + 12'h001) >= rtcw_wd_limit(r.wdog);
  end

  // Next-state logic for the whole sys_clk domain
  always_comb begin
    next_r = r;

    // Two-flop synchronisers; tick and kick add a third stage so their edges can be found
    next_r.tick_s = {r.tick_s[1:0], tick_level};
    next_r.ft_s   = {r.ft_s[0], ft_level};
    next_r.kick_s = {r.kick_s[1:0], watchdog_kick_input};
    next_r.batt_s = {r.batt_s[0], on_battery};
    next_r.pf_s   = {r.pf_s[0], power_fail};

    // Register pointer: load, then step after each access
    if (ptr_load) begin
      next_r.ptr = ptr_addr;
    end else if (reg_wr || reg_rd) begin
      next_r.ptr = r.ptr + 8'h01;
    end

    // Host writes
    // Unmapped and read-only addresses drop the data
    if (reg_wr) begin
      case (r.ptr)
        rtcw_pkg::ADDR_CTRL:     next_r.ctrl = reg_wdata[rtcw_pkg::CTRL_OUT_BIT:rtcw_pkg::CTRL_FT_BIT];
        rtcw_pkg::ADDR_WDOG:     next_r.wdog = reg_wdata;
        rtcw_pkg::ADDR_AL_MONTH: next_r.al_month = reg_wdata;
        rtcw_pkg::ADDR_AL_DATE:  next_r.al_date = reg_wdata;
        rtcw_pkg::ADDR_AL_HOUR:  next_r.al_hour = reg_wdata;
        rtcw_pkg::ADDR_AL_MIN:   next_r.al_min = reg_wdata;
        rtcw_pkg::ADDR_AL_SEC:   next_r.al_sec = reg_wdata;
        rtcw_pkg::ADDR_SQW:      next_r.rate = reg_wdata[7:rtcw_pkg::SQW_RS_LSB];
        default:                 next_r.rate = next_r.rate;
      endcase
    end

    // Host reads; unmapped addresses read zero
    if (reg_rd) begin
      case (r.ptr)
        rtcw_pkg::ADDR_CTRL:     next_r.rdata = {r.ctrl, 6'h00};
        rtcw_pkg::ADDR_WDOG:     next_r.rdata = r.wdog;
        rtcw_pkg::ADDR_AL_MONTH: next_r.rdata = r.al_month;
        rtcw_pkg::ADDR_AL_DATE:  next_r.rdata = r.al_date;
        rtcw_pkg::ADDR_AL_HOUR:  next_r.rdata = r.al_hour;
        rtcw_pkg::ADDR_AL_MIN:   next_r.rdata = r.al_min;
        rtcw_pkg::ADDR_AL_SEC:   next_r.rdata = r.al_sec;
        rtcw_pkg::ADDR_FLAGS:    next_r.rdata = {r.watchdog_flag, r.alarm_flag, 6'h00};
        rtcw_pkg::ADDR_SQW:      next_r.rdata = {r.rate, 4'h0};
        default:                 next_r.rdata = REG_ZERO;
      endcase
    end

    // Flags read clears; an event in the same cycle wins below
    if (rd_flags) begin
      next_r.alarm_flag    = 1'b0;
      next_r.alarm_irq     = 1'b0;
      next_r.watchdog_flag = 1'b0;
    end

    // Alarm delivery deferred while the pointer sits on the flags
    // Held as one pending event, so repeated matches are not stacked
    alarm_event = 1'b0;
    if (at_flags) begin
      next_r.alarm_pend = r.alarm_pend || hit;
    end else begin
      alarm_event       = hit || r.alarm_pend;
      next_r.alarm_pend = 1'b0;
    end
    if (alarm_event) begin
      next_r.alarm_flag = 1'b1;
      // Backup mode also needs its own enable
      if (r.al_month[rtcw_pkg::AM_AFE_BIT] &&
          (!r.batt_s[1] || r.al_month[rtcw_pkg::AM_ABE_BIT])) begin
        next_r.alarm_irq = 1'b1;
      end
    end

    // Watchdog count, restart and release
    // Count runs in 1/16 s ticks whatever the resolution
    if (wr_wdog || kick) begin
      next_r.wd_cnt  = 12'h000;
      next_r.wd_hold = 1'b0;
      if (wr_wdog && reg_wdata == REG_ZERO) begin
        next_r.wd_irq = 1'b0;
      end
    end else if (expire) begin
      next_r.wd_cnt        = 12'h000;
      next_r.watchdog_flag = 1'b1;
      if (!r.wdog[rtcw_pkg::WD_STEER_BIT]) begin
        // Stays stopped until a kick edge or a host write of the register
        next_r.wd_irq  = 1'b1;
        next_r.wd_hold = 1'b1;
      end else begin
        next_r.rst_cnt = HOLD_CYC;
        next_r.wdog    = REG_ZERO;
        next_r.ctrl[0] = 1'b0;
        next_r.al_month[rtcw_pkg::AM_AFE_BIT]  = 1'b0;
        next_r.al_month[rtcw_pkg::AM_ABE_BIT]  = 1'b0;
        next_r.al_month[rtcw_pkg::AM_SQUARE_WAVE_GATE_BIT] = 1'b0;
      end
    end else if (tick16 && wd_en && !r.wd_hold) begin
      next_r.wd_cnt = r.wd_cnt + 12'h001;
    end

    // Reset pin: held through power fail, then for the hold time
    // Open-drain data is always low; only the enable moves
    if (r.pf_s[1]) begin
      next_r.rst_cnt = HOLD_CYC;
    end else if (r.rst_cnt != 32'h0000_0000 && !expire) begin
      next_r.rst_cnt = r.rst_cnt - 32'h0000_0001;
    end
    next_r.rst_lvl  = 1'b0;
    next_r.rst_oe_n = !(r.pf_s[1] || r.rst_cnt != 32'h0000_0000);

    // Shared pin priority: interrupts, then test wave, then OUT level
    // Test wave yields to the alarm enable and an interrupt-steered watchdog
    next_r.pin_lvl = 1'b0;
    if (r.wd_irq || r.alarm_irq) begin
      next_r.pin_oe_n = 1'b0;
    end else if (r.ctrl[0] && !r.al_month[rtcw_pkg::AM_AFE_BIT] && !wd_to_irq) begin
      next_r.pin_oe_n = r.ft_s[1];
    end else if (!r.ctrl[0] && !r.al_month[rtcw_pkg::AM_AFE_BIT] && r.wdog == REG_ZERO) begin
      next_r.pin_oe_n = r.ctrl[1];
    end else begin
      next_r.pin_oe_n = 1'b1;
    end

    // Power-up state; reset pin held for the hold time afterwards
    if (!rstn) begin
      next_r          = '0;
      next_r.rst_cnt  = HOLD_CYC;
      next_r.pin_oe_n = 1'b1;
      next_r.rst_oe_n = 1'b0;
    end
  end

  // One register stage for the sys_clk domain
  always_ff @(posedge sys_clk) begin
    r <= next_r;
  end

  // Outputs straight from state flops
  assign reg_rdata                      = r.rdata;
  assign interrupt_test_output_pin_o    = r.pin_lvl;
  assign interrupt_test_output_pin_oe_n = r.pin_oe_n;
  assign reset_o                        = r.rst_lvl;
  assign reset_oe_n                     = r.rst_oe_n;

endmodule

//--- sim/rtcw_supervisor_monitor.sv
// Port checker of the clock supervisor, bound to its top module
module rtcw_supervisor_monitor #(
  parameter int unsigned RESET_HOLD_CYC = 20
) (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       ptr_load,
  input wire logic [7:0] ptr_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       power_fail,
  input wire logic       interrupt_test_output_pin_o,
  input wire logic       interrupt_test_output_pin_oe_n,
  input wire logic       reset_o,
  input wire logic       reset_oe_n
);
  logic [7:0]  ptr;
  logic [31:0] low_cnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  // Shadow pointer; a load wins over the post-access step
  always_ff @(posedge sys_clk) begin
    if (!rstn) ptr <= 8'h00;
    else if (ptr_load) ptr <= ptr_addr;
    else if (reg_rd || reg_wr) ptr <= ptr + 8'h01;
  end
  // Low time of the reset pin, not counted while power fail is high
  always_ff @(posedge sys_clk) begin
    if (!rstn || reset_oe_n || power_fail) low_cnt <= 32'h0;
    else low_cnt <= low_cnt + 32'h1;
  end
  a_pin_open_drain: assert property (interrupt_test_output_pin_o == 1'b0)
    else $error("interrupt pin data not low");
  a_rst_open_drain: assert property (reset_o == 1'b0)
    else $error("reset pin data not low");
  a_release_state: assert property ($rose(rstn) |-> reg_rdata == 8'h00 && !reset_oe_n)
    else $error("state at reset release wrong");
  a_flags_format: assert property (reg_rd && ptr == rtcw_pkg::ADDR_FLAGS |=> reg_rdata[5:0] == 6'h00)
    else $error("flags read has stray bits");
  a_rdata_hold: assert property ($changed(reg_rdata) |-> $past(reg_rd))
    else $error("read data moved without a read");
  a_pfail_pull: assert property (power_fail [*4] |=> !reset_oe_n)
    else $error("reset pin not pulled on power fail");
  a_hold_min: assert property ($rose(reset_oe_n) |-> low_cnt >= RESET_HOLD_CYC)
    else $error("reset pulse too short");
  a_hold_max: assert property (low_cnt <= RESET_HOLD_CYC + 4)
    else $error("reset pulse too long");
  c_pin_fell: cover property ($fell(interrupt_test_output_pin_oe_n));
  c_rst_rose: cover property ($rose(reset_oe_n));
  c_flag_read: cover property (reg_rd && ptr == rtcw_pkg::ADDR_FLAGS);
endmodule

bind rtcw_supervisor rtcw_supervisor_monitor #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) u_mon (
  .sys_clk(sys_clk), .rstn(rstn), .ptr_load(ptr_load), .ptr_addr(ptr_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_fail(power_fail),
  .interrupt_test_output_pin_o(interrupt_test_output_pin_o),
  .interrupt_test_output_pin_oe_n(interrupt_test_output_pin_oe_n), .reset_o(reset_o), .reset_oe_n(reset_oe_n));

//--- sim/rtcw_host_model.sv
// Host model driving the supervisor's register port
module rtcw_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            ptr_load,
  output logic      [7:0] ptr_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial begin
    ptr_load = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ptr_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Two cycles per access, so no strobe is set twice in one step
  task automatic setp(logic [7:0] a);
    ptr_load = 1'b1;
    ptr_addr = a;
    @(posedge sys_clk);
    #1;
    ptr_load = 1'b0;
    ptr_addr = ~a;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] d);
    reg_wr = 1'b1;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic rd(output logic [7:0] d);
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1;
    d = reg_rdata;
    reg_rd = 0;
    @(posedge sys_clk);
    #1;
  endtask
  // Alarm off: zero date and every repeat bit
  task automatic alarm_off();
    setp(rtcw_pkg::ADDR_AL_DATE);
    repeat (4) wr(8'h00);
  endtask
  // Zero write hands the interrupt pin back
  task automatic wd_off();
    setp(rtcw_pkg::ADDR_WDOG);
    wr(8'h00);
  endtask
endmodule

//--- sim/testbench.sv
// Self-checking bench of the clock supervisor
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [4:0]  rpt;
    logic [39:0] cur;
    logic [2:0]  bat_abe_af;
  } rtcw_row_t;
  localparam logic [39:0] AL = 40'h1215103045;
  localparam logic [39:0] DW = 40'h1114092946;
  logic        sys_clk, rstn, osc_clk, time_tick, on_battery, power_fail, kick, lows;
  logic        ptr_load, reg_wr, reg_rd, pin_o, pin_oe_n, rst_o, rst_oe_n, sqw;
  logic [7:0]  ptr_addr, reg_wdata, reg_rdata, v;
  logic [39:0] cur;
  rtcw_row_t   r;
  int          fail_count, checks_done, n, sq_cnt;
  int          exp_tr[5] = '{0, 200, 50, 25, 0};
  rtcw_row_t   rows[11] = '{{5'h1F, DW, 3'b001}, {5'h1E, 40'h1114092945, 3'b001},
    {5'h1E, 40'h1215103046, 3'b000}, {5'h1C, 40'h1114093045, 3'b001}, {5'h18, 40'h1114103045, 3'b001},
    {5'h10, 40'h1115103045, 3'b001}, {5'h00, AL, 3'b001}, {5'h00, 40'h1115103045, 3'b000},
    {5'h0A, DW, 3'b001}, {5'h1F, DW, 3'b101}, {5'h1F, DW, 3'b111}};
  rtcw_supervisor #(.RESET_HOLD_CYC(20)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .osc_clk(osc_clk),
    .ptr_load(ptr_load), .ptr_addr(ptr_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .time_tick(time_tick), .cur_month(cur[39:32]), .cur_date(cur[31:24]),
    .cur_hour(cur[23:16]), .cur_min(cur[15:8]), .cur_sec(cur[7:0]), .on_battery(on_battery),
    .power_fail(power_fail), .watchdog_kick_input(kick), .interrupt_test_output_pin_o(pin_o),
    .interrupt_test_output_pin_oe_n(pin_oe_n), .reset_o(rst_o), .reset_oe_n(rst_oe_n),
    .square_wave_output(sqw));
  rtcw_host_model u_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .ptr_load(ptr_load),
    .ptr_addr(ptr_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  // Clocks: link clock free running, phase unrelated
  always #5 sys_clk = ~sys_clk;
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #7.5 osc_clk = ~osc_clk;
  end
  // Square wave edge counter
  always @(sqw) sq_cnt++;
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(logic [39:0] t);
    cur = t;
    time_tick = 1'b1;
    step();
    time_tick = 1'b0;
    repeat (3) step();
  endtask
  // Alarm set to 12-15 10:30:45, interrupt enabled; ends on the flags address
  task automatic arm(logic [4:0] rpt, logic abe);
    u_host.setp(rtcw_pkg::ADDR_AL_MONTH);
    u_host.wr({2'b10, abe, 5'h12});
    u_host.wr({rpt[3], rpt[4], 6'h15});
    u_host.wr({rpt[2], 7'h10});
    u_host.wr({rpt[1], 7'h30});
    u_host.wr({rpt[0], 7'h45});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard: the tests need about 85,000 cycles at worst
  initial begin
    #950000;
    fail_count++;
    print_verdict();
  end
  initial begin
    sys_clk = 1'b0;
    rstn = 1'b0;
    time_tick = 1'b0;
    on_battery = 1'b0;
    power_fail = 1'b0;
    kick = 1'b0;
    cur = DW;
    repeat (10) step();
    chk("rst_pin", rst_oe_n, 8'h00);
    chk("irq_pin", pin_oe_n, 8'h01);
    repeat (10) step();
    rstn = 1'b1;
    u_host.setp(rtcw_pkg::ADDR_WDOG);
    u_host.rd(v);
    chk("wdog_rst", v, 8'h00);
    u_host.rd(v);
    chk("almon_rst", v, 8'h00);
    // Repeat modes, battery enables
    foreach (rows[i]) begin
      r = rows[i];
      on_battery = r.bat_abe_af[2];
      arm(r.rpt, r.bat_abe_af[1]);
      u_host.setp(8'h00);
      tick(r.cur);
      chk("pin", pin_oe_n, 8'(!(r.bat_abe_af[0] && (!r.bat_abe_af[2] || r.bat_abe_af[1]))));
      u_host.setp(rtcw_pkg::ADDR_FLAGS);
      u_host.rd(v);
      chk("flags", v, {1'b0, r.bat_abe_af[0], 6'h00});
    end
    on_battery = 1'b0;
    // Match while the pointer rests on flags after the seconds write
    arm(5'h1F, 1'b0);
    tick(DW);
    chk("held_pin", pin_oe_n, 8'h01);
    u_host.rd(v);
    chk("held_flags", v, 8'h00);
    repeat (3) step();
    chk("late_pin", pin_oe_n, 8'h00);
    u_host.setp(rtcw_pkg::ADDR_FLAGS);
    u_host.rd(v);
    chk("late_flags", v, 8'h40);
    u_host.setp(rtcw_pkg::ADDR_FLAGS);
    u_host.rd(v);
    chk("flags_clear", v, 8'h00);
    u_host.alarm_off();
    // Rate codes 0..3, then gate off
    for (int k = 0; k < 5; k++) begin
      u_host.setp(rtcw_pkg::ADDR_SQW);
      u_host.wr({(k < 4) ? 4'(k) : 4'h1, 4'h0});
      u_host.setp(rtcw_pkg::ADDR_AL_MONTH);
      u_host.wr({1'b1, k < 4, 6'h12});
      repeat (10) step();
      sq_cnt = 0;
      repeat (300) step();
      chk("sqw_edges", 8'(sq_cnt >= exp_tr[k] - 2 && sq_cnt <= exp_tr[k] + 2), 8'h01);
    end
    // Kicks faster than one sixteenth hold the timeout off
    u_host.setp(rtcw_pkg::ADDR_WDOG);
    u_host.wr(8'h08);
    lows = 1'b0;
    repeat (5) begin
      repeat (4000) begin
        step();
        if (pin_oe_n !== 1'b1) lows = 1'b1;
      end
      kick = ~kick;
    end
    chk("kick_hold", lows, 8'h00);
    n = 0;
    while (pin_oe_n !== 1'b0 && n < 20000) begin
      step();
      n++;
    end
    chk("wd_time", 8'(n >= 6000 && n <= 19000), 8'h01);
    u_host.setp(rtcw_pkg::ADDR_FLAGS);
    u_host.rd(v);
    chk("wdf", v, 8'h80);
    repeat (3) step();
    chk("wd_pin_kept", pin_oe_n, 8'h00);
    u_host.wd_off();
    repeat (3) step();
    chk("wd_pin_free", pin_oe_n, 8'h01);
    repeat (7000) step();
    chk("wd_stays_off", pin_oe_n, 8'h01);
    // Reset-steered, quarter second resolution, with enables set
    u_host.setp(rtcw_pkg::ADDR_CTRL);
    u_host.wr(8'h40);
    u_host.setp(rtcw_pkg::ADDR_AL_MONTH);
    u_host.wr(8'hF2);
    u_host.setp(rtcw_pkg::ADDR_WDOG);
    u_host.wr(8'h85);
    n = 0;
    while (rst_oe_n !== 1'b0 && n < 35000) begin
      step();
      n++;
    end
    chk("wd_rst_time", 8'(n >= 18000 && n <= 31000), 8'h01);
    n = 0;
    while (rst_oe_n !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk("wd_rst_width", 8'(n >= 19 && n <= 22), 8'h01);
    u_host.setp(rtcw_pkg::ADDR_CTRL);
    u_host.rd(v);
    chk("ft_cleared", v, 8'h00);
    u_host.rd(v);
    chk("wdog_cleared", v, 8'h00);
    u_host.rd(v);
    chk("enables_cleared", v, 8'h12);
    u_host.setp(rtcw_pkg::ADDR_FLAGS);
    u_host.rd(v);
    chk("wdf_rst", v, 8'h80);
    // Supply dip and hold after return
    power_fail = 1'b1;
    repeat (10) step();
    chk("pf_low", rst_oe_n, 8'h00);
    power_fail = 1'b0;
    n = 0;
    while (rst_oe_n !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    chk("pf_hold", 8'(n >= 20 && n <= 26), 8'h01);
    print_verdict();
  end
endmodule
